// *** design/rmpm_pin_mux.sv ***
// Reset-mode strap capture, external bus pin multiplexing, flag and interrupt pins
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

//Contract
// R1 - The four mode straps are sampled only during reset and afterwards act as general flags.
// R2 - The operating mode is latched from the host-mode strap in reset and fixed until next reset.
// R3 - Host-mode strap 0 selects full memory mode and 1 selects host mode.
// R4 - Full memory mode enables byte DMA with full external access; host mode enables host DMA.
// R5 - Each shared pin carries exactly one signal, chosen by the latched mode.
// R6 - Full memory mode drives 14 address bits and 24 data bits, upper 8 also byte address.
// R7 - In host mode the host drives a 16-bit muxed bus and select, read, write and latch inputs.
// R8 - In host mode the acknowledge is open drain, its sense chosen by the second strap; the code uses strap D (STRAP_ACK, bit 3).
// R9 - Host mode still provides address bit 0, upper 16 data bits and the space selects; the code has no space select outputs.
// R10 - Interrupt/flag pins keep both functions, the interrupt seeing the pin while driven.
// R11 - An asserted shared pin with its mask bit set interrupts, whoever drives the pin.
// R12 - Interrupt two is edge or level selectable, the low pair level only, the edge pin edge only.
// R13 - Serial port b pins switch to two interrupts plus flag in and out under a control bit.
// R14 - Bus pins are configured only in reset; serial pin functions change at run time.
// R15 - Mode bits are captured at the edge where reset falls and held until the next reset.
module rmpm_pin_mux
   import rmpm_pkg::*;
(
   input  wire logic                CLK_SYS,
   input  wire logic                SYS_RST,
   input  wire rmpm_reg_req_t       REG_REQ,
   output logic     [DATA_W-1:0]    REG_RDATA,
   output logic                     IRQ,
   output logic     [N_INT-1:0]     INT_REQ,
   output logic                     HOST_MODE,
   output logic                     BYTE_DMA_EN,
   output logic                     HOST_DMA_EN,
   input  wire logic [13:0]         CORE_ADDR,
   input  wire logic [23:0]         CORE_DATA_OUT,
   input  wire logic                CORE_DATA_OE,
   output logic     [23:0]          CORE_DATA_IN,
   input  wire logic                CORE_BYTE_ACC,
   input  wire logic [7:0]          CORE_BYTE_ADDR_HI,
   input  wire logic                CORE_ADDR_OE,
   input  wire logic [15:0]         HOST_AD_OUT,
   input  wire logic                HOST_AD_OE,
   input  wire logic                HOST_READY,
   output logic     [15:0]          HOST_AD_IN,
   output logic                     HOST_SELECT_N,
   output logic                     HOST_READ_EN_N,
   output logic                     HOST_WRITE_EN_N,
   output logic                     HOST_ADDR_LATCH,
   input  wire logic [13:0]         ADDR_PIN_IN,
   output logic     [13:0]          ADDR_PIN_OUT,
   output logic     [13:0]          ADDR_PIN_OE,
   input  wire logic [23:0]         DATA_PIN_IN,
   output logic     [23:0]          DATA_PIN_OUT,
   output logic     [23:0]          DATA_PIN_OE,
   input  wire logic [N_PF-1:0]     PF_IN,
   output logic     [N_PF-1:0]      PF_OUT,
   output logic     [N_PF-1:0]      PF_OE,
   input  wire logic [4:0]          SPB_CORE_OUT,
   input  wire logic [4:0]          SPB_CORE_OE,
   output logic     [4:0]           SPB_CORE_IN,
   input  wire logic [4:0]          SPB_PIN_IN,
   output logic     [4:0]           SPB_PIN_OUT,
   output logic     [4:0]           SPB_PIN_OE,
   output logic                     FLAG_IN,
   output logic     [2:0]           FIXED_OUTPUT_FLAGS
);

   logic [3:0]        mode_straps;
   rmpm_mode_t        mode;
   logic [CTRL_W-1:0] ctrl;
   logic [N_PF-1:0]   flag_dir;
   logic [N_PF-1:0]   flag_val;
   logic [N_INT-1:0]  int_status;
   logic [N_INT-1:0]  int_mask;
   logic [N_INT-1:0]  int_level;
   logic [N_INT-1:0]  int_level_q;
   logic [N_INT-1:0]  int_edge_sel;
   logic [N_INT-1:0]  int_event;
   logic [N_INT-1:0]  int_clear;
   logic              spb_alt;
   logic              host;

   logic [13:0]       next_addr_out;
   logic [13:0]       next_addr_oe;
   logic [23:0]       next_data_out;
   logic [23:0]       next_data_oe;
   logic [4:0]        next_spb_out;
   logic [4:0]        next_spb_oe;

   // Write decodes share one address compare; the read mux decodes the address in a case
   function automatic logic hit(input rmpm_reg_req_t r, input logic [ADDR_W-1:0] ofs);
      hit = (r.addr == ofs);
   endfunction : hit

   // Straps load on every reset edge; the last load is the edge where reset falls
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         mode_straps <= PF_IN[3:0]; // [R1] [R2] [R15]
      end
   end

   assign host        = mode_straps[STRAP_HOST]; // [R2]
   assign mode        = host ? MODE_HOST : MODE_FULL; // [R3]
   assign HOST_MODE   = (mode == MODE_HOST);
   assign BYTE_DMA_EN = (mode == MODE_FULL); // [R4]
   assign HOST_DMA_EN = (mode == MODE_HOST); // [R4]
   assign spb_alt     = ctrl[CTRL_SPB_ALT];

   // Control, flag and mask registers
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ctrl <= RST_CTRL;
      end else if (REG_REQ.wr && hit(REG_REQ, OFS_CTRL)) begin
         ctrl <= REG_REQ.wdata[CTRL_W-1:0]; // [R13] [R14]
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         flag_dir <= RST_DIR;
         flag_val <= RST_FLAGS;
      end else begin
         if (REG_REQ.wr && hit(REG_REQ, OFS_FLAG_DIR)) begin
            flag_dir <= REG_REQ.wdata[N_PF-1:0];
         end
         if (REG_REQ.wr && hit(REG_REQ, OFS_FLAG_OUT)) begin
            flag_val <= REG_REQ.wdata[N_PF-1:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         int_mask <= RST_MASK;
      end else if (REG_REQ.wr && hit(REG_REQ, OFS_MASK)) begin
         int_mask <= REG_REQ.wdata[N_INT-1:0];
      end
   end

   // Flag pins: straps stay inputs in reset, then follow the direction register
   always_comb begin
      PF_OUT = flag_val;
      PF_OE  = SYS_RST ? '0 : flag_dir; // [R1]
   end

   // Interrupt sources are active low; the pin input is read even while driven
   always_comb begin
      int_level                = '0;
      int_level[INT_EXT_TWO]   = ~PF_IN[PF_EXT_TWO]; // [R10]
      int_level[INT_LEVEL_ONE] = ~PF_IN[PF_LEVEL_ONE];
      int_level[INT_LEVEL_ZRO] = ~PF_IN[PF_LEVEL_ZRO];
      int_level[INT_EDGE]      = ~PF_IN[PF_EDGE];
      int_level[INT_SPB_ZERO]  = spb_alt & ~SPB_PIN_IN[SPB_INT0]; // [R13]
      int_level[INT_SPB_ONE]   = spb_alt & ~SPB_PIN_IN[SPB_INT1]; // [R13]
   end

   always_comb begin
      int_edge_sel                = '0;
      int_edge_sel[INT_EXT_TWO]   = ctrl[CTRL_TWO_EDGE]; // [R12]
      int_edge_sel[INT_EDGE]      = 1'b1; // [R12]
      int_edge_sel[INT_SPB_ZERO]  = ctrl[CTRL_SPI0_EDGE];
      int_edge_sel[INT_SPB_ONE]   = ctrl[CTRL_SPI1_EDGE];
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         int_level_q <= '0;
      end else begin
         int_level_q <= int_level;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_INT; gi++) begin : g_int
         assign int_event[gi] = int_edge_sel[gi] ? (int_level[gi] & ~int_level_q[gi])
                                                 : int_level[gi]; // [R12]
         assign int_clear[gi] = REG_REQ.wr && hit(REG_REQ, OFS_STATUS) && REG_REQ.wdata[gi];
         // A new event wins over a clear in the same cycle
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               int_status[gi] <= 1'b0;
            end else if (int_event[gi]) begin
               int_status[gi] <= 1'b1; // [R11]
            end else if (int_clear[gi]) begin
               int_status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign INT_REQ = int_status & int_mask; // [R11]
   assign IRQ     = |INT_REQ; // [R11]

   // Address pins: full address in full mode, address bit 0 only in host mode
   always_comb begin
      next_addr_out = CORE_ADDR; // [R6]
      next_addr_oe  = {14{CORE_ADDR_OE}};
      if (host) begin
         next_addr_out[13:1] = HOST_AD_OUT[12:0]; // [R5]
         next_addr_oe[13:1]  = {13{HOST_AD_OE}}; // [R5]
         next_addr_oe[0]     = CORE_ADDR_OE; // [R9]
      end
   end

   // Data pins: full 24-bit bus, or upper 16 bits plus host port lines
   always_comb begin
      next_data_out = CORE_DATA_OUT;
      next_data_oe  = {24{CORE_DATA_OE}};
      if (!host && CORE_BYTE_ACC) begin
         next_data_out[23:16] = CORE_BYTE_ADDR_HI; // [R6]
         next_data_oe[23:16]  = 8'hff; // [R6]
      end
      if (host) begin
         next_data_out[2:0]      = HOST_AD_OUT[15:13]; // [R5]
         next_data_oe[2:0]       = {3{HOST_AD_OE}};
         next_data_out[HPIN_ACK] = 1'b0; // [R8]
         next_data_oe[HPIN_ACK]  = mode_straps[STRAP_ACK] ? ~HOST_READY : HOST_READY; // [R8]
         next_data_out[7:4]      = 4'h0;
         next_data_oe[7:4]       = 4'h0; // [R7]
      end
   end

   // Serial port b pins: serial function, or flag out on its pin in alternate mode
   always_comb begin
      next_spb_out = SPB_CORE_OUT;
      next_spb_oe  = SPB_CORE_OE;
      if (spb_alt) begin
         next_spb_out[SPB_INT1:SPB_INT0] = 2'h0;
         next_spb_oe[SPB_INT1:SPB_INT0]  = 2'h0; // [R13]
         next_spb_out[SPB_FI]            = 1'b0;
         next_spb_oe[SPB_FI]             = 1'b0;
         next_spb_out[SPB_FO]            = ctrl[CTRL_FLAG_OUT]; // [R13]
         next_spb_oe[SPB_FO]             = 1'b1;
      end
   end

   // Pin drivers; all released while reset is held
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ADDR_PIN_OUT <= '0;
         ADDR_PIN_OE  <= '0;
         DATA_PIN_OUT <= '0;
         DATA_PIN_OE  <= '0;
      end else begin
         ADDR_PIN_OUT <= next_addr_out;
         ADDR_PIN_OE  <= next_addr_oe;
         DATA_PIN_OUT <= next_data_out;
         DATA_PIN_OE  <= next_data_oe;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         SPB_PIN_OUT <= '0;
         SPB_PIN_OE  <= '0;
      end else begin
         SPB_PIN_OUT <= next_spb_out;
         SPB_PIN_OE  <= next_spb_oe; // [R14]
      end
   end

   // Inbound pin values toward the core and the host port
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         CORE_DATA_IN    <= '0;
         HOST_AD_IN      <= '0;
         HOST_SELECT_N   <= 1'b1;
         HOST_READ_EN_N  <= 1'b1;
         HOST_WRITE_EN_N <= 1'b1;
         HOST_ADDR_LATCH <= 1'b0;
         SPB_CORE_IN     <= '0;
         FLAG_IN         <= 1'b0;
      end else begin
         CORE_DATA_IN    <= DATA_PIN_IN;
         HOST_AD_IN      <= host ? {DATA_PIN_IN[2:0], ADDR_PIN_IN[13:1]} : 16'h0000;
         HOST_SELECT_N   <= host ? DATA_PIN_IN[HPIN_SEL] : 1'b1; // [R7]
         HOST_READ_EN_N  <= host ? DATA_PIN_IN[HPIN_RD] : 1'b1; // [R7]
         HOST_WRITE_EN_N <= host ? DATA_PIN_IN[HPIN_WR] : 1'b1; // [R7]
         HOST_ADDR_LATCH <= host ? DATA_PIN_IN[HPIN_ALE] : 1'b0; // [R7]
         SPB_CORE_IN     <= SPB_PIN_IN;
         FLAG_IN         <= spb_alt ? SPB_PIN_IN[SPB_FI] : 1'b0; // [R13]
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         FIXED_OUTPUT_FLAGS <= '0;
      end else begin
         FIXED_OUTPUT_FLAGS <= ctrl[CTRL_FIXED_LSB +: 3];
      end
   end

   // Read data stands in the cycle after the read strobe only
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !REG_REQ.rd) begin
         REG_RDATA <= '0;
      end else begin
         case (REG_REQ.addr)
            OFS_CTRL:     REG_RDATA <= {{(DATA_W-CTRL_W){1'b0}}, ctrl};
            OFS_FLAG_DIR: REG_RDATA <= {{(DATA_W-N_PF){1'b0}}, flag_dir};
            OFS_FLAG_OUT: REG_RDATA <= {{(DATA_W-N_PF){1'b0}}, flag_val};
            OFS_STATUS:   REG_RDATA <= {{(DATA_W-N_INT){1'b0}}, int_status};
            OFS_MASK:     REG_RDATA <= {{(DATA_W-N_INT){1'b0}}, int_mask};
            OFS_MODE:     REG_RDATA <= {27'h0, host, mode_straps};
            OFS_PINS:     REG_RDATA <= {23'h0, FLAG_IN, PF_IN};
            default:      REG_RDATA <= '0;
         endcase
      end
   end

endmodule : rmpm_pin_mux

`default_nettype wire

// *** design/rmpm_pkg.sv ***
// Package: constants, register map and carriers of the reset-mode pin multiplexer
package rmpm_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int N_INT  = 6;
   localparam int N_PF   = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FLAG_DIR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FLAG_OUT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PINS     = 8'h18;

   // Control register fields
   localparam int CTRL_SPB_ALT    = 0;
   localparam int CTRL_TWO_EDGE   = 1;
   localparam int CTRL_SPI0_EDGE  = 2;
   localparam int CTRL_SPI1_EDGE  = 3;
   localparam int CTRL_FLAG_OUT   = 4;
   localparam int CTRL_FIXED_LSB  = 5;
   localparam int CTRL_W          = 8;

   // Interrupt status and mask bit positions
   localparam int INT_EXT_TWO   = 0;
   localparam int INT_LEVEL_ONE = 1;
   localparam int INT_LEVEL_ZRO = 2;
   localparam int INT_EDGE      = 3;
   localparam int INT_SPB_ZERO  = 4;
   localparam int INT_SPB_ONE   = 5;

   // Programmable flag pins shared with interrupts
   localparam int PF_EXT_TWO   = 7;
   localparam int PF_LEVEL_ONE = 6;
   localparam int PF_LEVEL_ZRO = 5;
   localparam int PF_EDGE      = 4;

   // Mode straps on flag pins 3..0 (A..D = 0..3)
   localparam int STRAP_HOST = 2;
   localparam int STRAP_ACK  = 3;

   // Data pins that carry host control in host mode
   localparam int HPIN_ACK = 3;
   localparam int HPIN_SEL = 4;
   localparam int HPIN_ALE = 5;
   localparam int HPIN_RD  = 6;
   localparam int HPIN_WR  = 7;

   // Serial port b pins in alternate mode
   localparam int SPB_INT0 = 0;
   localparam int SPB_INT1 = 1;
   localparam int SPB_FI   = 2;
   localparam int SPB_FO   = 3;

   // Reset values
   localparam logic [CTRL_W-1:0] RST_CTRL  = 8'h00;
   localparam logic [N_PF-1:0]   RST_DIR   = 8'h00;
   localparam logic [N_PF-1:0]   RST_FLAGS = 8'hff;
   localparam logic [N_INT-1:0]  RST_MASK  = 6'h00;

   typedef enum logic [1:0] {
      MODE_FULL = 2'b01,
      MODE_HOST = 2'b10
   } rmpm_mode_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rmpm_reg_req_t;

endpackage : rmpm_pkg

// *** dv/rmpm_ext_model.sv ***
// Far-side model: host or memory on the bus pins, pull-ups on the flag pins
`timescale 1ns/10ps
`default_nettype none
module rmpm_ext_model (
   input  wire logic [7:0]  PF_OUT,
   input  wire logic [7:0]  PF_OE,
   input  wire logic [7:0]  EXT_PF,
   input  wire logic [7:0]  EXT_PF_OE,
   output logic      [7:0]  PF_IN,
   input  wire logic [23:0] DATA_PIN_OUT,
   input  wire logic [23:0] DATA_PIN_OE,
   input  wire logic [23:0] EXT_D,
   input  wire logic [23:0] EXT_D_OE,
   output logic      [23:0] DATA_PIN_IN,
   input  wire logic [13:0] ADDR_PIN_OUT,
   input  wire logic [13:0] ADDR_PIN_OE,
   input  wire logic [13:0] EXT_A,
   output logic      [13:0] ADDR_PIN_IN
);
   // Undriven flag pins sit at the pull-up
   assign PF_IN = (PF_OE & PF_OUT) | (~PF_OE & EXT_PF_OE & EXT_PF) | ~(PF_OE | EXT_PF_OE);
   // Released data pins show the inverse of the last value, so a stale level never passes
   assign DATA_PIN_IN = (DATA_PIN_OE & DATA_PIN_OUT) | (~DATA_PIN_OE & EXT_D_OE & EXT_D)
                      | (~DATA_PIN_OE & ~EXT_D_OE & ~DATA_PIN_OUT);
   // Host drives the address half whenever the device does not
   assign ADDR_PIN_IN = (ADDR_PIN_OE & ADDR_PIN_OUT) | (~ADDR_PIN_OE & EXT_A);
endmodule : rmpm_ext_model
`default_nettype wire

// *** dv/rmpm_pin_mux_properties.sv ***
// Checker: mode latch, pin routing and interrupt properties of the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module rmpm_pin_mux_properties
   import rmpm_pkg::*;
(
   input wire logic             CLK_SYS,
   input wire logic             SYS_RST,
   input wire logic             IRQ,
   input wire logic [N_INT-1:0] INT_REQ,
   input wire logic             HOST_MODE,
   input wire logic             BYTE_DMA_EN,
   input wire logic             HOST_DMA_EN,
   input wire logic [13:0]      CORE_ADDR,
   input wire logic             CORE_ADDR_OE,
   input wire logic             HOST_AD_OE,
   input wire logic [15:0]      HOST_AD_OUT,
   input wire logic [13:0]      ADDR_PIN_IN,
   input wire logic [13:0]      ADDR_PIN_OUT,
   input wire logic [13:0]      ADDR_PIN_OE,
   input wire logic [23:0]      DATA_PIN_IN,
   input wire logic [23:0]      DATA_PIN_OUT,
   input wire logic [23:0]      DATA_PIN_OE,
   input wire logic [N_PF-1:0]  PF_OE,
   input wire logic [N_PF-1:0]  PF_IN,
   input wire logic             HOST_SELECT_N,
   input wire logic [15:0]      HOST_AD_IN
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   // First edge with reset low
   sequence s_release;
      $past(SYS_RST) && !SYS_RST;
   endsequence

   a_mode_strap: assert property (s_release |->
      HOST_MODE == $past(PF_IN[STRAP_HOST])) else $error("mode differs from strap");
   a_mode_hold: assert property (!$past(SYS_RST) |->
      $stable(HOST_MODE) && $stable(BYTE_DMA_EN)) else $error("mode changed out of reset");
   a_dma_select: assert property (HOST_DMA_EN == HOST_MODE && BYTE_DMA_EN == !HOST_MODE)
      else $error("dma port enables disagree with mode");
   a_flags_reset: assert property (disable iff (1'b0) SYS_RST |-> PF_OE == '0)
      else $error("flag pin driven during reset");
   a_addr_route: assert property (!HOST_MODE && CORE_ADDR_OE |=>
      ADDR_PIN_OUT == $past(CORE_ADDR)) else $error("address pins not following core");
   a_addr_host: assert property (HOST_MODE |=>
      ADDR_PIN_OE[13:1] == {13{$past(HOST_AD_OE)}}
      && ADDR_PIN_OUT[13:1] == $past(HOST_AD_OUT[12:0]))
      else $error("host address pins not from host port");
   a_host_select: assert property (HOST_MODE |=>
      HOST_SELECT_N == $past(DATA_PIN_IN[HPIN_SEL])) else $error("select not from pin");
   a_host_bus: assert property (HOST_MODE |=>
      HOST_AD_IN[12:0] == $past(ADDR_PIN_IN[13:1])) else $error("host bus not from pins");
   a_ack_drain: assert property (HOST_MODE && DATA_PIN_OE[HPIN_ACK] |->
      !DATA_PIN_OUT[HPIN_ACK]) else $error("acknowledge driven high");
   a_irq_sum: assert property (IRQ == |INT_REQ)
      else $error("irq disagrees with requests");
endmodule : rmpm_pin_mux_properties

bind rmpm_pin_mux rmpm_pin_mux_properties rmpm_pin_mux_properties_i (.*);
`default_nettype wire

// *** dv/tb_rmpm_pin_mux.sv ***
// Testbench: mode straps, pin routing, flags, interrupts and serial alternate pins
`timescale 1ns/10ps
`default_nettype none
module tb_rmpm_pin_mux;
   import rmpm_pkg::*;
   logic          CLK_SYS, SYS_RST = 1'b1, HOST_READY = 1'b0, HOST_AD_OE = 1'b0;
   logic          CORE_DATA_OE = 1'b0, CORE_BYTE_ACC = 1'b0, CORE_ADDR_OE = 1'b0;
   logic          IRQ, HOST_MODE, BYTE_DMA_EN, HOST_DMA_EN, FLAG_IN;
   logic          HOST_SELECT_N, HOST_READ_EN_N, HOST_WRITE_EN_N, HOST_ADDR_LATCH;
   rmpm_reg_req_t REG_REQ = '0;
   logic [31:0]   REG_RDATA;
   logic [13:0]   CORE_ADDR = '0, EXT_A = '0, ADDR_PIN_IN, ADDR_PIN_OUT, ADDR_PIN_OE;
   logic [23:0]   CORE_DATA_OUT = '0, EXT_D = '0, EXT_D_OE = '0;
   logic [23:0]   CORE_DATA_IN, DATA_PIN_IN, DATA_PIN_OUT, DATA_PIN_OE;
   logic [15:0]   HOST_AD_OUT = '0, HOST_AD_IN;
   logic [7:0]    CORE_BYTE_ADDR_HI = '0, EXT_PF = '0, EXT_PF_OE = '0, PF_IN, PF_OUT, PF_OE;
   logic [5:0]    INT_REQ;
   logic [4:0]    SPB_CORE_OUT = '0, SPB_CORE_OE = '0, SPB_PIN_IN = 5'h1f;
   logic [4:0]    SPB_CORE_IN, SPB_PIN_OUT, SPB_PIN_OE;
   logic [2:0]    FIXED_OUTPUT_FLAGS;
   int            fail_count = 0;
   int            samples_checked = 0;

   rmpm_pin_mux rmpm_pin_mux_i (.*);
   rmpm_ext_model rmpm_ext_model_i (.*);

   initial begin
      CLK_SYS = 1'b0;
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      REG_REQ <= '{1'b1, 1'b0, a, d};
      @(posedge CLK_SYS);
      REG_REQ <= '0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK_SYS);
      REG_REQ <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge CLK_SYS);
      REG_REQ <= '0;
      @(negedge CLK_SYS);
      check(REG_RDATA, exp);
   endtask : reg_rd

   task automatic settle;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask : settle

   // Straps are held by the far side through reset and released with it
   task automatic do_reset(input logic [3:0] straps);
      @(posedge CLK_SYS);
      SYS_RST   <= 1'b1;
      EXT_PF    <= {4'h0, straps};
      EXT_PF_OE <= 8'h0f;
      repeat (6) @(posedge CLK_SYS);
      SYS_RST   <= 1'b0;
      EXT_PF_OE <= 8'h00;
   endtask : do_reset

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (5000) @(posedge CLK_SYS);
      fail_count++;
      end_of_test();
   end

   initial begin
      do_reset(4'h9);
      reg_rd(OFS_MODE, 32'h09);
      check({HOST_MODE, BYTE_DMA_EN, HOST_DMA_EN}, 3'b010);
      reg_rd(OFS_PINS, 32'hff);
      reg_rd(8'h40, 32'h0);
      @(posedge CLK_SYS);
      CORE_ADDR     <= 14'h2a5c;
      CORE_ADDR_OE  <= 1'b1;
      CORE_DATA_OUT <= 24'h123456;
      CORE_DATA_OE  <= 1'b1;
      settle();
      check({ADDR_PIN_OE, ADDR_PIN_OUT}, {14'h3fff, 14'h2a5c});
      check(DATA_PIN_OE, 24'hffffff);
      @(posedge CLK_SYS);
      CORE_BYTE_ACC     <= 1'b1;
      CORE_BYTE_ADDR_HI <= 8'hc3;
      settle();
      check(DATA_PIN_OUT, 24'hc33456);
      $display("test full memory pins done");
      // Flag pin 4 driven low by its own output raises the edge interrupt
      reg_wr(OFS_MASK, 32'h08);
      reg_wr(OFS_FLAG_DIR, 32'h10);
      reg_wr(OFS_FLAG_OUT, 32'hef);
      settle();
      check(IRQ, 1'b1);
      check(INT_REQ, 6'h08);
      check(CORE_DATA_IN, 24'hc33456);
      reg_rd(OFS_PINS, 32'hef);
      reg_rd(OFS_STATUS, 32'h08);
      reg_wr(OFS_STATUS, 32'h08);
      reg_wr(OFS_CTRL, 32'ha2);
      @(posedge CLK_SYS);
      EXT_PF_OE <= 8'ha0;
      settle();
      check({IRQ, FIXED_OUTPUT_FLAGS}, 4'b0101);
      reg_rd(OFS_STATUS, 32'h05);
      reg_wr(OFS_STATUS, 32'h05);
      reg_rd(OFS_STATUS, 32'h04);
      @(posedge CLK_SYS);
      EXT_PF_OE  <= 8'h00;
      SPB_PIN_IN <= 5'h1e;
      reg_wr(OFS_STATUS, 32'h3f);
      reg_rd(OFS_STATUS, 32'h00);
      reg_wr(OFS_CTRL, 32'h11);
      reg_rd(OFS_STATUS, 32'h10);
      check({FLAG_IN, SPB_PIN_OE[SPB_FO], SPB_PIN_OUT[SPB_FO]}, 3'b111);
      check(SPB_CORE_IN, 5'h1e);
      // Both serial interrupts in edge mode: a held low pin does not set again
      reg_wr(OFS_CTRL, 32'h1d);
      reg_wr(OFS_STATUS, 32'h3f);
      @(posedge CLK_SYS);
      SPB_PIN_IN <= 5'h1c;
      reg_rd(OFS_STATUS, 32'h20);
      $display("test flags and interrupts done");
      @(posedge CLK_SYS);
      EXT_D         <= 24'h0000a5;
      EXT_D_OE      <= 24'h0000f7;
      EXT_A         <= 14'h1234;
      HOST_READY    <= 1'b1;
      CORE_ADDR     <= 14'h0001;
      CORE_DATA_OUT <= 24'hbeef00;
      CORE_BYTE_ACC <= 1'b0;
      do_reset(4'h4);
      settle();
      check({HOST_MODE, BYTE_DMA_EN, HOST_DMA_EN}, 3'b101);
      reg_rd(OFS_MODE, 32'h14);
      check({HOST_SELECT_N, HOST_READ_EN_N, HOST_WRITE_EN_N, HOST_ADDR_LATCH}, 4'b0011);
      check(HOST_AD_IN, {3'b101, 13'h091a});
      check({DATA_PIN_OE[7:0], DATA_PIN_OUT[HPIN_ACK]}, {8'h08, 1'b0});
      check({ADDR_PIN_OE, ADDR_PIN_OUT[0]}, {14'h0001, 1'b1});
      check({DATA_PIN_OE[23:8], DATA_PIN_OUT[23:8]}, {16'hffff, 16'hbeef});
      @(posedge CLK_SYS);
      HOST_READY <= 1'b0;
      settle();
      check(DATA_PIN_OE[HPIN_ACK], 1'b0);
      @(posedge CLK_SYS);
      HOST_AD_OUT <= 16'hb5a3;
      HOST_AD_OE  <= 1'b1;
      settle();
      check({ADDR_PIN_OE[13:1], ADDR_PIN_OUT[13:1]}, {13'h1fff, 13'h15a3});
      check({DATA_PIN_OE[2:0], DATA_PIN_OUT[2:0]}, 6'b111101);
      $display("test host mode done");
      end_of_test();
   end
endmodule : tb_rmpm_pin_mux
`default_nettype wire
